/* File: design/fddi_regs.svh */
// timing constants for the flexible disk drive link
`ifndef FDDI_REGS_SVH
`define FDDI_REGS_SVH
`define FDDI_CLK_MHZ 250
`define FDDI_STEP_MIN_NS 200
`define FDDI_STEP_MIN_CYC ((`FDDI_STEP_MIN_NS * `FDDI_CLK_MHZ + 999) / 1000)
`define FDDI_STEP_GAP_US 5000
`define FDDI_STEP_GAP_CYC (`FDDI_STEP_GAP_US * `FDDI_CLK_MHZ)
`define FDDI_RD_PULSE_NS 1000
`define FDDI_RD_PULSE_CYC (`FDDI_RD_PULSE_NS * `FDDI_CLK_MHZ / 1000)
`define FDDI_REV_US 200000
`define FDDI_REV_CYC (`FDDI_REV_US * `FDDI_CLK_MHZ)
`define FDDI_IDX_US 4000
`define FDDI_IDX_CYC (`FDDI_IDX_US * `FDDI_CLK_MHZ)
`define FDDI_TRK_MAX 8'h27
`define FDDI_WR_LOW_NS 500
`define FDDI_WR_LOW_CYC (`FDDI_WR_LOW_NS * `FDDI_CLK_MHZ / 1000)
`define FDDI_FIFO_W 1
`define FDDI_FIFO_D 8
`endif

/* File: design/fddi_pkg.sv */
// types shared by both ends of the flexible disk drive link
package fddi_pkg;
	typedef enum logic [1:0]
	{
		FDDI_H_IDLE = 2'b00,
		FDDI_H_STEP = 2'b01,
		FDDI_H_GAP = 2'b10
	} fddi_hst_t;
endpackage

/* File: design/fddi_if.sv */
// interface carrying the drive cable lines, all active low
`timescale 1ns/1ps
interface fddi_if;
	logic sel_n;
	logic dir_n;
	logic step_n;
	logic wdata_n;
	logic wgate_n;
	logic side_n;
	logic index_n;
	logic trk0_n;
	logic wprot_n;
	logic rdata_n;
	modport drive
	(
		input sel_n, dir_n, step_n, wdata_n, wgate_n, side_n,
		output index_n, trk0_n, wprot_n, rdata_n
	);
	modport ctrl
	(
		output sel_n, dir_n, step_n, wdata_n, wgate_n, side_n,
		input index_n, trk0_n, wprot_n, rdata_n
	);
endinterface

/* File: design/fddi_fifo.sv */
// small valid/ready fifo with parameter width and depth
`timescale 1ns/1ps
module fddi_fifo #(
	parameter int W = 1,
	parameter int D = 8
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	assign in_ready = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: design/fddi_drive.sv */
// drive end: stepping, write gating, index and read pulses
// Behaviour
// - unselected drive ignores inputs except side select, outputs inactive except head_upper
// - step low over 200 ns requests one track
// - direction sampled at step; low moves inward
// - motion starts on step rising edge
// - controller spaces step trailing edges 5 ms
// - drop step: writing, outward at home, unselected
// - write data falling edge flips write current
// - controller writes fm edges 125/250 kHz
// - controller may precompensate mfm about 250 ns
// - write enable low: write on, read off
// - write enable high: write path off
// - protected diskette blocks writing always
// - side select high lower head, low upper
// - index low every revolution for 4 ms
// - controller times index from falling edge
// - sector holes merged only for hard sectored
// - home output low while head on track zero
// - protect output low for protected diskette
// - one 1 us low read pulse per flux
// - read pulse falling edge marks flux position
`timescale 1ns/1ps
`include "fddi_regs.svh"
module fddi_drive
	import fddi_pkg::*;
#(
	parameter int REV_CYC = `FDDI_REV_CYC,
	parameter int IDX_CYC = `FDDI_IDX_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// cable
	fddi_if.drive bus,
	// media side
	input wire logic media_protected,
	input wire logic media_hard_sector,
	input wire logic sector_hole,
	input wire logic flux_in,
	output logic wr_current,
	output logic wr_gate,
	output logic head_upper,
	output logic rd_enable,
	output logic [7:0] track
);
	// ***************************************************
	// state
	// ***************************************************
	typedef struct packed
	{
		logic [2:0] sel_s;
		logic [2:0] dir_s;
		logic [2:0] step_s;
		logic [2:0] wd_s;
		logic [2:0] wg_s;
		logic [2:0] side_s;
		logic [2:0] flx_s;
		logic [2:0] sec_s;
		logic [2:0] prot_s;
		logic [2:0] hs_s;
		logic [7:0] low_cnt;
		logic step_ok;
		logic step_dir;
		logic [7:0] trk;
		logic wcur;
		logic [27:0] rev_cnt;
		logic [7:0] rd_cnt;
		logic index_n;
		logic trk0_n;
		logic wprot_n;
		logic rdata_n;
		logic wgate;
		logic upper;
		logic rd_en;
	} fddi_dst_t;
	fddi_dst_t s_r, s_nxt;
	logic sel;
	logic wr_allow;
	// select rises once the second and third stages are both high, and drops as soon as the second goes low
	assign sel = s_r.sel_s[1] & s_r.sel_s[2];
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sel_s = {s_r.sel_s[1:0], ~bus.sel_n};
		s_nxt.dir_s = {s_r.dir_s[1:0], ~bus.dir_n};
		s_nxt.step_s = {s_r.step_s[1:0], ~bus.step_n};
		s_nxt.wd_s = {s_r.wd_s[1:0], ~bus.wdata_n};
		s_nxt.wg_s = {s_r.wg_s[1:0], ~bus.wgate_n};
		s_nxt.side_s = {s_r.side_s[1:0], ~bus.side_n};
		s_nxt.flx_s = {s_r.flx_s[1:0], flux_in};
		s_nxt.sec_s = {s_r.sec_s[1:0], sector_hole};
		// media switches are pins too, so they pass the same chain
		s_nxt.prot_s = {s_r.prot_s[1:0], media_protected};
		s_nxt.hs_s = {s_r.hs_s[1:0], media_hard_sector};
		// ***************************************************
		// stepping
		// ***************************************************
		if (s_r.step_s[2] && s_r.step_s[1])
		begin
			if (s_r.low_cnt != 8'hFF)
				s_nxt.low_cnt = s_r.low_cnt + 8'h01;
			if (s_r.low_cnt == 8'(`FDDI_STEP_MIN_CYC))
				s_nxt.step_ok = 1'b1;
			s_nxt.step_dir = s_r.dir_s[2];
		end
		if (s_r.step_s[2] && !s_r.step_s[1])
		begin
			// trailing edge; drop while writing or unselected
			s_nxt.low_cnt = 8'h00;
			s_nxt.step_ok = 1'b0;
			if (s_r.step_ok && sel && !s_r.wg_s[2])
			begin
				if (s_r.step_dir && s_r.trk != `FDDI_TRK_MAX)
					s_nxt.trk = s_r.trk + 8'h01;
				else if (!s_r.step_dir && s_r.trk != 8'h00)
					s_nxt.trk = s_r.trk - 8'h01;
			end
		end
		if (!s_r.step_s[2] && !s_r.step_s[1])
		begin
			s_nxt.low_cnt = 8'h00;
			s_nxt.step_ok = 1'b0;
		end
		// ***************************************************
		// writing
		// ***************************************************
		wr_allow = sel && s_r.wg_s[2] && !s_r.prot_s[2];
		s_nxt.wgate = wr_allow;
		s_nxt.rd_en = sel && !s_r.wg_s[2];
		s_nxt.upper = s_r.side_s[2];
		if (wr_allow && !s_r.wd_s[2] && s_r.wd_s[1])
			s_nxt.wcur = ~s_r.wcur;
		// ***************************************************
		// status outputs
		// ***************************************************
		s_nxt.rev_cnt = (s_r.rev_cnt >= 28'(REV_CYC - 1)) ? 28'h0000000
			: s_r.rev_cnt + 28'h0000001;
		s_nxt.index_n = !(sel && ((s_r.rev_cnt < 28'(IDX_CYC))
			|| (s_r.hs_s[2] && s_r.sec_s[2])));
		s_nxt.trk0_n = !(sel && s_r.trk == 8'h00);
		s_nxt.wprot_n = !(sel && s_r.prot_s[2]);
		// reading: pulse starts on the detected transition
		if (s_r.rd_cnt != 8'h00)
			s_nxt.rd_cnt = s_r.rd_cnt - 8'h01;
		if (s_r.flx_s[1] && !s_r.flx_s[2] && sel && !s_r.wg_s[2])
			s_nxt.rd_cnt = 8'(`FDDI_RD_PULSE_CYC);
		// deselection cuts a running pulse so the line goes idle
		if (!sel)
			s_nxt.rd_cnt = 8'h00;
		s_nxt.rdata_n = (s_nxt.rd_cnt == 8'h00);
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r <= '0;
			s_r.index_n <= 1'b1;
			s_r.trk0_n <= 1'b1;
			s_r.wprot_n <= 1'b1;
			s_r.rdata_n <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end
	assign bus.index_n = s_r.index_n;
	assign bus.trk0_n = s_r.trk0_n;
	assign bus.wprot_n = s_r.wprot_n;
	assign bus.rdata_n = s_r.rdata_n;
	assign wr_current = s_r.wcur;
	assign wr_gate = s_r.wgate;
	assign head_upper = s_r.upper;
	assign rd_enable = s_r.rd_en;
	assign track = s_r.trk;
endmodule

/* File: design/fddi_ctrl.sv */
// controller end: steps the head and streams write flux pulses
`timescale 1ns/1ps
`include "fddi_regs.svh"
module fddi_ctrl
	import fddi_pkg::*;
#(
	parameter int GAP_CYC = `FDDI_STEP_GAP_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// cable
	fddi_if.ctrl bus,
	// user side
	input wire logic select,
	input wire logic step_req,
	input wire logic step_in,
	output logic step_busy,
	input wire logic side_upper,
	input wire logic write_on,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic wr_flux,
	output logic home,
	output logic protect,
	output logic index_fall,
	output logic rd_fall
);
	// ***************************************************
	// state
	// ***************************************************
	typedef struct packed
	{
		fddi_hst_t st;
		logic [20:0] cnt;
		logic dir_n;
		logic busy;
		logic step_n;
		logic [7:0] wcnt;
		logic wd_n;
		logic [2:0] idx_s;
		logic [2:0] rd_s;
		logic [2:0] t0_s;
		logic [2:0] wp_s;
		logic home;
		logic prot;
		logic idx_f;
		logic rd_f;
		logic sel_n;
		logic wg_n;
		logic side_n;
	} fddi_cst_t;
	fddi_cst_t s_r, s_nxt;
	logic f_valid, f_ready, f_data, f_full_ok;
	// fifo stalls the user when the cable side lags
	fddi_fifo #(.W(`FDDI_FIFO_W), .D(`FDDI_FIFO_D)) u_fifo
	(
		.clk(clk),
		.rstn(rstn),
		.in_valid(wr_valid),
		.in_ready(f_full_ok),
		.in_data(wr_flux),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);
	assign f_ready = (s_r.wcnt == 8'h00) && !s_r.wg_n;
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sel_n = !select;
		s_nxt.wg_n = !(write_on && s_r.wp_s[2]);
		s_nxt.side_n = !side_upper;
		s_nxt.idx_s = {s_r.idx_s[1:0], bus.index_n};
		s_nxt.rd_s = {s_r.rd_s[1:0], bus.rdata_n};
		s_nxt.t0_s = {s_r.t0_s[1:0], bus.trk0_n};
		s_nxt.wp_s = {s_r.wp_s[1:0], bus.wprot_n};
		s_nxt.home = !s_r.t0_s[2] && !s_r.t0_s[1];
		s_nxt.prot = !s_r.wp_s[2] && !s_r.wp_s[1];
		s_nxt.idx_f = s_r.idx_s[2] && !s_r.idx_s[1];
		s_nxt.rd_f = s_r.rd_s[2] && !s_r.rd_s[1];
		// ***************************************************
		// stepping
		// ***************************************************
		case (s_r.st)
			FDDI_H_IDLE:
			begin
				if (step_req && select && s_r.wg_n)
				begin
					s_nxt.dir_n = !step_in;
					s_nxt.step_n = 1'b0;
					s_nxt.cnt = 21'(2 * `FDDI_STEP_MIN_CYC);
					s_nxt.st = FDDI_H_STEP;
				end
			end
			FDDI_H_STEP:
			begin
				s_nxt.cnt = s_r.cnt - 21'h000001;
				if (s_r.cnt == 21'h000000)
				begin
					s_nxt.step_n = 1'b1;
					s_nxt.cnt = 21'(GAP_CYC);
					s_nxt.st = FDDI_H_GAP;
				end
			end
			FDDI_H_GAP:
			begin
				s_nxt.cnt = s_r.cnt - 21'h000001;
				if (s_r.cnt == 21'h000000)
					s_nxt.st = FDDI_H_IDLE;
			end
			default:
				s_nxt.st = FDDI_H_IDLE;
		endcase
		s_nxt.busy = (s_nxt.st != FDDI_H_IDLE);
		// ***************************************************
		// write flux: one low pulse per fifo word set
		// ***************************************************
		if (s_r.wcnt != 8'h00)
			s_nxt.wcnt = s_r.wcnt - 8'h01;
		// low for the first half of the slot, high for the rest
		if (s_r.wcnt == 8'(`FDDI_WR_LOW_CYC + 1))
			s_nxt.wd_n = 1'b1;
		if (f_valid && f_ready)
		begin
			s_nxt.wcnt = 8'(2 * `FDDI_WR_LOW_CYC);
			s_nxt.wd_n = !f_data;
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r <= '0;
			s_r.step_n <= 1'b1;
			s_r.dir_n <= 1'b1;
			s_r.wd_n <= 1'b1;
			s_r.idx_s <= 3'h7;
			s_r.rd_s <= 3'h7;
			s_r.t0_s <= 3'h7;
			s_r.wp_s <= 3'h7;
			s_r.sel_n <= 1'b1;
			s_r.wg_n <= 1'b1;
			s_r.side_n <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end
	assign bus.sel_n = s_r.sel_n;
	assign bus.dir_n = s_r.dir_n;
	assign bus.step_n = s_r.step_n;
	assign bus.wdata_n = s_r.wd_n;
	assign bus.wgate_n = s_r.wg_n;
	assign bus.side_n = s_r.side_n;
	assign step_busy = s_r.busy;
	assign wr_ready = f_full_ok;
	assign home = s_r.home;
	assign protect = s_r.prot;
	assign index_fall = s_r.idx_f;
	assign rd_fall = s_r.rd_f;
endmodule

/* File: bench/fddi_props.sv */
// assertions on the drive cable lines
`timescale 1ns/1ps
module fddi_props #(
	parameter int GAP_CYC = 200,
	parameter int REV_CYC = 2000
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// controller to drive
	input wire logic sel_n,
	input wire logic dir_n,
	input wire logic step_n,
	input wire logic wdata_n,
	input wire logic wgate_n,
	input wire logic side_n,
	// drive to controller
	input wire logic index_n,
	input wire logic trk0_n,
	input wire logic wprot_n,
	input wire logic rdata_n
);
	// ********
	// counters
	// ********
	int step_lo_r;
	int gap_r;
	int rd_lo_r;
	int idx_hi_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			step_lo_r <= 0;
			gap_r <= GAP_CYC;
			rd_lo_r <= 0;
			idx_hi_r <= 0;
		end
		else
		begin
			step_lo_r <= step_n ? 0 : step_lo_r + 1;
			gap_r <= step_n ? gap_r + 1 : 0;
			rd_lo_r <= rdata_n ? 0 : rd_lo_r + 1;
			idx_hi_r <= (sel_n || !index_n) ? 0 : idx_hi_r + 1;
		end
	end
	// ********
	// properties
	// ********
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// the 3-flop input sync delays effects, hence the 8-cycle holds
	sequence s_step_held;
		(!sel_n && !step_n) [*8];
	endsequence
	a_unsel_idle: assert property (sel_n [*8] |->
		index_n && trk0_n && wprot_n && rdata_n)
		else $error("unselected drive drives status");
	a_step_width: assert property ($rose(step_n) |->
		step_lo_r inside {[100:102]})
		else $error("step low width wrong");
	a_step_gap: assert property ($fell(step_n) |->
		gap_r >= GAP_CYC - 4)
		else $error("step pulses too close");
	a_dir_held: assert property (!step_n && $past(!step_n) |->
		$stable(dir_n))
		else $error("direction moved during step");
	a_home_held: assert property (s_step_held |->
		$stable(trk0_n))
		else $error("home moved before step end");
	a_rd_width: assert property ($rose(rdata_n) |->
		rd_lo_r inside {[188:312]})
		else $error("read pulse width wrong");
	a_index_due: assert property (idx_hi_r <= REV_CYC + 8)
		else $error("index pulse missing");
	a_prot_nowrite: assert property ((!wprot_n) [*8] |->
		wgate_n)
		else $error("write gate on protected disk");
endmodule

/* File: bench/flexible_disk_drive_interface_tb_top.sv */
// bench joining controller and drive ends over the cable
`timescale 1ns/1ps
module flexible_disk_drive_interface_tb_top;
	// ********
	// stimulus and dut
	// ********
	// counts shortened so a revolution lasts 2000 cycles
	localparam int GAP = 200;
	localparam int REV = 2000;
	logic clk = 0;
	logic rstn = 0;
	logic select = 1;
	logic step_req = 0;
	logic step_in = 0;
	logic side_upper = 0;
	logic write_on = 0;
	logic wr_valid = 0;
	logic wr_flux = 0;
	logic media_protected = 0;
	logic media_hard_sector = 0;
	logic sector_hole = 0;
	logic flux_in = 0;
	logic wc_q = 0;
	logic step_busy, wr_ready, home, protect, index_fall, rd_fall;
	logic wr_current, wr_gate, head_upper, rd_enable;
	logic [7:0] track;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n_rd = 0;
	int n_idx = 0;
	int n_wr = 0;
	int r;
	int k;
	always #2 clk = ~clk;
	fddi_if cable();
	fddi_ctrl #(.GAP_CYC(GAP)) i_fddi_ctrl (.clk, .rstn, .bus(cable),
		.select, .step_req, .step_in, .step_busy, .side_upper, .write_on,
		.wr_valid, .wr_ready, .wr_flux, .home, .protect, .index_fall,
		.rd_fall);
	fddi_drive #(.REV_CYC(REV), .IDX_CYC(100)) i_fddi_drive (.clk,
		.rstn, .bus(cable), .media_protected, .media_hard_sector,
		.sector_hole, .flux_in, .wr_current, .wr_gate, .head_upper,
		.rd_enable, .track);
	fddi_props #(.GAP_CYC(GAP), .REV_CYC(REV)) i_fddi_props (.clk,
		.rstn, .sel_n(cable.sel_n), .dir_n(cable.dir_n),
		.step_n(cable.step_n), .wdata_n(cable.wdata_n),
		.wgate_n(cable.wgate_n), .side_n(cable.side_n),
		.index_n(cable.index_n), .trk0_n(cable.trk0_n),
		.wprot_n(cable.wprot_n), .rdata_n(cable.rdata_n));
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		wc_q <= wr_current;
		n_wr <= n_wr + (wr_current ^ wc_q);
		n_rd <= n_rd + rd_fall;
		n_idx <= n_idx + index_fall;
		if (cyc == 40000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	// ********
	// tasks
	// ********
	task tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(string what, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task step(logic inward);
		step_in = inward;
		step_req = 1;
		for (k = 0; k < 20 && step_busy !== 1'b1; k++)
			tick(1);
		step_req = 0;
		for (k = 0; k < 600 && step_busy !== 1'b0; k++)
			tick(1);
		tick(10);
	endtask
	// leaves valid high so back-to-back words need no gap
	task push(logic b);
		wr_valid = 1;
		wr_flux = b;
		for (k = 0; k < 600 && wr_ready !== 1'b1; k++)
			tick(1);
		tick(1);
	endtask
	task flux(int n);
		r = n_rd;
		repeat (n)
		begin
			flux_in = 1;
			tick(3);
			flux_in = 0;
			tick(400);
		end
	endtask
	task idx_win(logic hs, logic [7:0] exp);
		media_hard_sector = hs;
		for (k = 0; k < 3000 && index_fall !== 1'b1; k++)
			tick(1);
		tick(1);
		r = n_idx;
		repeat (2)
		begin
			tick(500);
			sector_hole = 1;
			tick(30);
			sector_hole = 0;
		end
		tick(1940);
		chk("index", exp, n_idx - r);
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ********
	// tests
	// ********
	initial
	begin
		tick(3);
		rstn = 1;
		// select, sync chains and home status take nine cycles
		tick(12);
		chk("home", 1, home);
		repeat (3)
			step(1);
		chk("track", 8'h03, track);
		chk("home", 0, home);
		repeat (4)
			step(0);
		chk("track", 8'h00, track);
		$display("step test done");
		select = 0;
		tick(8);
		chk("trk0_n", 1, cable.trk0_n);
		step(1);
		flux(1);
		chk("read", 0, n_rd - r);
		select = 1;
		tick(8);
		flux(3);
		chk("read", 3, n_rd - r);
		chk("track", 8'h00, track);
		chk("rd_enable", 1, rd_enable);
		$display("select test done");
		write_on = 1;
		tick(8);
		chk("wr_gate", 1, wr_gate);
		chk("rd_enable", 0, rd_enable);
		r = n_wr;
		push(1);
		push(0);
		push(1);
		wr_valid = 0;
		step(1);
		tick(500);
		chk("track", 8'h00, track);
		chk("write", 2, n_wr - r);
		wr_valid = 1;
		r = 0;
		for (k = 0; k < 20; k++)
		begin
			r += (wr_ready === 1'b1);
			tick(1);
		end
		chk("wr_ready", 0, wr_ready);
		wr_valid = 0;
		chk("filled", 1, r >= 8);
		tick(2800);
		chk("wr_ready", 1, wr_ready);
		write_on = 0;
		tick(8);
		chk("wr_gate", 0, wr_gate);
		media_protected = 1;
		tick(12);
		chk("protect", 1, protect);
		write_on = 1;
		r = n_wr;
		push(1);
		wr_valid = 0;
		tick(300);
		chk("wr_gate", 0, wr_gate);
		chk("write", 0, n_wr - r);
		write_on = 0;
		media_protected = 0;
		for (k = 0; k < 2; k++)
		begin
			side_upper = k[0];
			tick(8);
			chk("head_upper", k[0], head_upper);
		end
		$display("write test done");
		idx_win(0, 1);
		idx_win(1, 3);
		$display("index test done");
		print_verdict();
	end
endmodule
